/* rtl/smi_event_aggregator.v */
// system management interrupt aggregator with avalon-mm registers
// assumes unit requests are synchronous to i_clock, active high,
// and the two infrared receive pins are asynchronous
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "smi_defs.vh"
module smi_event_aggregator (
  input wire i_clock,                   // 50 mhz system clock
  input wire i_rstn,                    // synchronous reset, active low
  input wire [9:0] i_avs_address,       // byte address
  input wire i_avs_read,                // read request
  input wire i_avs_write,               // write request
  input wire [31:0] i_avs_writedata,    // write data
  input wire [3:0] i_avs_byteenable,    // byte lanes
  output reg [31:0] o_avs_readdata,     // read data
  output reg o_avs_waitrequest,         // stall, low on completion
  input wire i_parallel_req,            // parallel port request
  input wire i_uart_b_req,              // second uart request
  input wire i_uart_a_req,              // first uart request
  input wire i_floppy_req,              // floppy controller request
  input wire i_watchdog_req,            // watchdog request
  input wire i_mouse_req,               // mouse request
  input wire i_keyboard_req,            // keyboard request
  input wire i_kbc_port_line,           // keyboard controller line
  input wire i_ir_rx_primary,           // infrared receive pin a
  input wire i_ir_rx_alternate,         // infrared receive pin b
  input wire i_ir_rx_select,            // 1 selects pin b
  output reg o_group_sysmgmt_irq_n,     // group request, active low
  output reg o_serial_irq_smi_req,      // request for serial irq frame
  output reg o_irq                      // event interrupt, active high
);

  // byte addresses built from the register indices
  localparam [9:0] ADDR_ENABLE_1 = {`IDX_ENABLE_1, 2'b00};
  localparam [9:0] ADDR_ENABLE_2 = {`IDX_ENABLE_2, 2'b00};
  localparam [9:0] ADDR_STATUS_1 = {`IDX_STATUS_1, 2'b00};
  localparam [9:0] ADDR_STATUS_2 = {`IDX_STATUS_2, 2'b00};
  localparam [9:0] ADDR_AUX_RSVD = {`IDX_AUX_RSVD, 2'b00};
  localparam [9:0] ADDR_EVENT = {`IDX_EVENT, 2'b00};
  localparam [9:0] ADDR_EVENT_MASK = {`IDX_EVENT_MASK, 2'b00};

  // register map by index, byte address is index * 4
  //   b4 enable 1: unit gates at bits 1 to 4 and 7
  //   b5 enable 2: mouse, keyboard, infrared, port line, serial forward
  //   b6 status 1: unit request mirrors, writes ignored
  //   b7 status 2: mirrors plus infrared flag, flag cleared by read
  //   b8 aux: plain storage with no function
  //   b9 events: one bit per status bit rise, write one to clear
  //   ba event mask: a one lets that event reach o_irq

  // software registers
  reg [7:0] enable_1_reg;
  reg [7:0] enable_2_reg;
  reg [7:0] aux_reg;
  reg [15:0] event_mask_reg;

  // mirrored unit requests
  reg parallel_req_flag;
  reg uart_b_req_flag;
  reg uart_a_req_flag;
  reg floppy_req_flag;
  reg watchdog_req_flag;
  reg mouse_req_flag;
  reg keyboard_req_flag;
  reg kbc_port_line_flag;
  wire infrared_activity_flag;

  // previous status snapshot for event edges
  reg [7:0] status_1_prev_reg;
  reg [7:0] status_2_prev_reg;
  reg ir_level_prev_reg;

  // bus handshake state
  reg [31:0] readdata_next;
  wire bus_req;
  wire bus_done;
  wire write_done;
  wire read_done;
  wire lane0;
  wire lane1;

  // address decode, one select per register except status 1
  wire sel_enable_1;
  wire sel_enable_2;
  wire sel_status_2;
  wire sel_aux;
  wire sel_event;
  wire sel_event_mask;

  // assembled status views
  wire [7:0] status_1;
  wire [7:0] status_2;
  wire [15:0] event_flags;
  wire [15:0] event_set;
  wire [15:0] event_clear;

  // infrared path
  wire [1:0] ir_pins_sync;
  wire ir_level;
  wire ir_edge;
  wire ir_clear;

  // group request terms
  wire [7:0] group_terms_1;
  wire [7:0] group_terms_2;
  wire group_active;

  // the request is accepted on the edge after the stall cycle
  assign bus_req = i_avs_read | i_avs_write;
  assign bus_done = bus_req & ~o_avs_waitrequest;
  assign write_done = bus_done & i_avs_write;
  assign read_done = bus_done & i_avs_read;
  assign lane0 = i_avs_byteenable[0];
  assign lane1 = i_avs_byteenable[1];

  // full address compare; the two low bits must be zero to hit
  assign sel_enable_1 = (i_avs_address == ADDR_ENABLE_1);
  assign sel_enable_2 = (i_avs_address == ADDR_ENABLE_2);
  assign sel_status_2 = (i_avs_address == ADDR_STATUS_2);
  assign sel_aux = (i_avs_address == ADDR_AUX_RSVD);
  assign sel_event = (i_avs_address == ADDR_EVENT);
  assign sel_event_mask = (i_avs_address == ADDR_EVENT_MASK);

  // one stall cycle per access, then waitrequest drops for one edge;
  // a request still held after its completing edge counts as a new
  // access and is answered again after one more stall
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
    end
  end

  // mirror the unit requests; they clear only at their source
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      parallel_req_flag <= 1'b0;
      uart_b_req_flag <= 1'b0;
      uart_a_req_flag <= 1'b0;
      floppy_req_flag <= 1'b0;
      watchdog_req_flag <= 1'b0;
    end else begin
      parallel_req_flag <= i_parallel_req;
      uart_b_req_flag <= i_uart_b_req;
      uart_a_req_flag <= i_uart_a_req;
      floppy_req_flag <= i_floppy_req;
      watchdog_req_flag <= i_watchdog_req;
    end
  end

  // second group mirrors; only the infrared flag is read-cleared
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      mouse_req_flag <= 1'b0;
      keyboard_req_flag <= 1'b0;
      kbc_port_line_flag <= 1'b0;
    end else begin
      mouse_req_flag <= i_mouse_req;
      keyboard_req_flag <= i_keyboard_req;
      kbc_port_line_flag <= i_kbc_port_line;
    end
  end

  // both receive pins are synchronised before the selector
  pin_sync #(
    .WIDTH(2)
  ) u_ir_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_async({i_ir_rx_alternate, i_ir_rx_primary}),
    .o_sync(ir_pins_sync)
  );

  // edge taken after the pin selector; a select change may count.
  // reset leaves the history low, so a pin that idles high gives one
  // spurious edge once reset is released
  assign ir_level = i_ir_rx_select ? ir_pins_sync[1] : ir_pins_sync[0];
  assign ir_edge = ir_level ^ ir_level_prev_reg;

  always @(posedge i_clock) begin
    if (!i_rstn) begin
      ir_level_prev_reg <= 1'b0;
    end else begin
      ir_level_prev_reg <= ir_level;
    end
  end

  // clear only what the host actually saw, so late edges survive
  assign ir_clear = read_done &
                    sel_status_2 &
                    o_avs_readdata[`BIT_INFRARED];

  // one sticky bit holds the infrared activity
  sticky_bits #(
    .WIDTH(1)
  ) u_ir_flag (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_set(ir_edge),
    .i_clear(ir_clear),
    .o_flags(infrared_activity_flag)
  );

  // status register 1 layout, unused bits zero
  assign status_1 = {watchdog_req_flag, 2'b00, floppy_req_flag,
                     uart_a_req_flag, uart_b_req_flag,
                     parallel_req_flag, 1'b0};

  // status register 2 layout, unused bits zero
  assign status_2 = {3'b000, kbc_port_line_flag, 1'b0,
                     infrared_activity_flag, keyboard_req_flag,
                     mouse_req_flag};

  // each source is passed only through its own enable bit
  assign group_terms_1 = status_1 & enable_1_reg &
                         `MASK_GROUP_1;
  assign group_terms_2 = status_2 & enable_2_reg &
                         `MASK_GROUP_2;
  assign group_active = |{group_terms_1, group_terms_2};

  // group output and serial irq forward, both registered
  // so the pins cannot glitch while enables change
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      o_group_sysmgmt_irq_n <= 1'b1;
      o_serial_irq_smi_req <= 1'b0;
    end else begin
      o_group_sysmgmt_irq_n <= ~group_active;
      o_serial_irq_smi_req <= group_active &
                              enable_2_reg[`BIT_SERIAL_FWD];
    end
  end

  // software enables; status registers ignore writes
  // reserved enable bits are masked so they always read zero
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      enable_1_reg <= `RST_ENABLE;
      enable_2_reg <= `RST_ENABLE;
      aux_reg <= `RST_AUX;
      event_mask_reg <= `RST_MASK;
    end else if (write_done) begin
      if (lane0 && sel_enable_1) begin
        enable_1_reg <= i_avs_writedata[7:0] & `MASK_GROUP_1;
      end
      if (lane0 && sel_enable_2) begin
        enable_2_reg <= i_avs_writedata[7:0] & `MASK_ENABLE_2;
      end
      if (lane0 && sel_aux) begin
        aux_reg <= i_avs_writedata[7:0];
      end
      if (sel_event_mask) begin
        if (lane0) begin
          event_mask_reg[7:0] <= i_avs_writedata[7:0];
        end
        if (lane1) begin
          event_mask_reg[15:8] <= i_avs_writedata[15:8];
        end
      end
    end
  end

  // previous status for rising-edge events
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      status_1_prev_reg <= 8'h00;
      status_2_prev_reg <= 8'h00;
    end else begin
      status_1_prev_reg <= status_1;
      status_2_prev_reg <= status_2;
    end
  end

  // a new request on any source raises its event bit;
  // a request already high at reset release still counts as new
  assign event_set = {status_2 & ~status_2_prev_reg,
                      status_1 & ~status_1_prev_reg};

  // write one to clear, per byte lane
  assign event_clear = (write_done && sel_event) ?
                       (i_avs_writedata[15:0] &
                        {{8{lane1}}, {8{lane0}}}) : 16'h0000;

  // an event landing on its own clear survives, set wins
  sticky_bits #(
    .WIDTH(16)
  ) u_events (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_set(event_set),
    .i_clear(event_clear),
    .o_flags(event_flags)
  );

  // level interrupt from unmasked events
  // stays high until software clears the event or masks it
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(event_flags & event_mask_reg);
    end
  end

  // read mux; unmapped addresses read zero
  // reserved bits of the enable, status and event registers read zero as well; aux and event mask keep every written bit
  always @* begin
    readdata_next = 32'h00000000;
    case (i_avs_address)
      ADDR_ENABLE_1: readdata_next[7:0] = enable_1_reg;
      ADDR_ENABLE_2: readdata_next[7:0] = enable_2_reg;
      ADDR_STATUS_1: readdata_next[7:0] = status_1;
      ADDR_STATUS_2: readdata_next[7:0] = status_2;
      ADDR_AUX_RSVD: readdata_next[7:0] = aux_reg;
      ADDR_EVENT: readdata_next[15:0] = event_flags;
      ADDR_EVENT_MASK: readdata_next[15:0] = event_mask_reg;
      default: readdata_next = 32'h00000000;
    endcase
  end

  // data captured in the stall cycle, valid at the completing edge
  // and held until the next read, so a slow master still sees it
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= readdata_next;
    end
  end

endmodule

/* common/smi_defs.vh */
// constants for the system management interrupt aggregator
// assumes a 32-bit avalon-mm slave port with byte addresses
`ifndef SMI_DEFS_VH
`define SMI_DEFS_VH

// register indices; byte address is four times the index
`define IDX_ENABLE_1 8'hB4
`define IDX_ENABLE_2 8'hB5
`define IDX_STATUS_1 8'hB6
`define IDX_STATUS_2 8'hB7
`define IDX_AUX_RSVD 8'hB8
`define IDX_EVENT 8'hB9
`define IDX_EVENT_MASK 8'hBA

// reset values
`define RST_ENABLE 8'h00
`define RST_AUX 8'h00
`define RST_MASK 16'h0000

// first enable and status layout
`define BIT_PARALLEL 1
`define BIT_UART_B 2
`define BIT_UART_A 3
`define BIT_FLOPPY 4
`define BIT_WATCHDOG 7
// second enable and status layout
`define BIT_MOUSE 0
`define BIT_KEYBOARD 1
`define BIT_INFRARED 2
`define BIT_KBC_LINE 4
`define BIT_SERIAL_FWD 6

// implemented bits of each layout
`define MASK_GROUP_1 8'h9E
`define MASK_GROUP_2 8'h17
`define MASK_ENABLE_2 8'h57

`endif

/* rtl/pin_sync.v */
// two flip-flop synchroniser for a group of asynchronous pins
// assumes the pins are quasi-static relative to i_clock edges
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1
) (
  input wire i_clock,               // system clock
  input wire i_rstn,                // synchronous reset, active low
  input wire [WIDTH-1:0] i_async,   // raw pin levels
  output reg [WIDTH-1:0] o_sync     // synchronised levels
);

  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      meta_reg <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule

/* rtl/sticky_bits.v */
// vector of sticky flags with independent set and clear per bit
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
module sticky_bits #(
  parameter WIDTH = 1
) (
  input wire i_clock,               // system clock
  input wire i_rstn,                // synchronous reset, active low
  input wire [WIDTH-1:0] i_set,     // one-cycle set pulses
  input wire [WIDTH-1:0] i_clear,   // one-cycle clear pulses
  output reg [WIDTH-1:0] o_flags    // held flags
);

  // set beats clear so an event landing on a clear is kept
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      o_flags <= {WIDTH{1'b0}};
    end else begin
      o_flags <= (o_flags & ~i_clear) | i_set;
    end
  end

endmodule

/* dv/smi_event_aggregator_properties.sv */
// port checker for the smi aggregator, bound into the design
// assumes smi_defs.vh on the include path and one clock domain
`timescale 1ns/1ps
`include "smi_defs.vh"
module smi_event_aggregator_properties (
  input wire i_clock,
  input wire i_rstn,
  input wire [9:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire i_parallel_req,
  input wire i_uart_b_req,
  input wire i_uart_a_req,
  input wire i_floppy_req,
  input wire i_watchdog_req,
  input wire i_mouse_req,
  input wire i_keyboard_req,
  input wire i_kbc_port_line,
  input wire i_ir_rx_primary,
  input wire i_ir_rx_alternate,
  input wire i_ir_rx_select,
  input wire o_group_sysmgmt_irq_n,
  input wire o_serial_irq_smi_req,
  input wire o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  reg [7:0] en1_reg;
  reg [7:0] en2_reg;
  reg [7:0] src1_reg;
  reg [7:0] src2_reg;
  wire [7:0] idx = i_avs_address[9:2];
  wire req = i_avs_read || i_avs_write;
  wire fin_w = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  wire fin_r = i_avs_read && !o_avs_waitrequest;
  wire mapped = idx >= `IDX_ENABLE_1 && idx <= `IDX_EVENT_MASK;
  wire [7:0] src1 = {i_watchdog_req, 2'b00, i_floppy_req, i_uart_a_req,
    i_uart_b_req, i_parallel_req, 1'b0};
  wire [7:0] src2 = {3'b000, i_kbc_port_line, 2'b00, i_keyboard_req,
    i_mouse_req};
  // infrared flag is sticky, so it is kept out of the level source set
  wire hit = (|(src1_reg & en1_reg)) || (|(src2_reg & en2_reg & 8'h13));
  // sources as the status flops hold them, one edge after the pins
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      src1_reg <= 8'h00;
      src2_reg <= 8'h00;
    end else begin
      src1_reg <= src1;
      src2_reg <= src2;
    end
  end
  // shadow of the enable registers, updated at write completion
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      en1_reg <= 8'h00;
      en2_reg <= 8'h00;
    end else if (fin_w && idx == `IDX_ENABLE_1) begin
      en1_reg <= i_avs_writedata[7:0] & `MASK_GROUP_1;
    end else if (fin_w && idx == `IDX_ENABLE_2) begin
      en2_reg <= i_avs_writedata[7:0] & `MASK_ENABLE_2;
    end
  end
  a_group_low_hit: assert property (hit
    |=> !o_group_sysmgmt_irq_n)
    else $error("group output not low for enabled source");
  a_group_high_idle: assert property ((!hit && !en2_reg[2])
    |=> o_group_sysmgmt_irq_n)
    else $error("group output low with no enabled source");
  a_serial_needs_group: assert property (o_serial_irq_smi_req
    |-> !o_group_sysmgmt_irq_n)
    else $error("serial request without group request");
  a_serial_gated: assert property (!$past(en2_reg[6])
    |-> !o_serial_irq_smi_req)
    else $error("serial request while forwarding disabled");
  a_wait_one_stall: assert property ((req && o_avs_waitrequest)
    |=> !o_avs_waitrequest)
    else $error("access not answered after one stall");
  a_wait_one_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_zero: assert property ((fin_r && !mapped)
    |-> o_avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (fin_r |-> o_avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_status1_layout: assert property ((fin_r && idx == `IDX_STATUS_1)
    |-> (o_avs_readdata[7:0] & ~`MASK_GROUP_1) == 8'h00)
    else $error("reserved status bit set");
  c_group_hit: cover property (hit [*2]);
  c_serial: cover property (o_serial_irq_smi_req);
  c_irq: cover property (o_irq);
endmodule
bind smi_event_aggregator smi_event_aggregator_properties i_props (.*);

/* dv/smi_host_model.sv */
// host side model counting group interrupt entries
// assumes the group line idles high between requests
`timescale 1ns/1ps
module smi_host_model (
  input wire i_clock,        // system clock
  input wire i_rstn,         // synchronous reset, active low
  input wire i_group_n,      // group request, active low
  output reg [7:0] o_entries // falling edges seen
);
  reg last_reg;
  // an entry is a high to low step; a held level counts once
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      last_reg <= 1'b1;
      o_entries <= 8'h00;
    end else begin
      last_reg <= i_group_n;
      if (last_reg && !i_group_n)
        o_entries <= o_entries + 8'h01;
    end
  end
endmodule

/* dv/smi_event_aggregator_tb.sv */
// self-checking bench for the smi aggregator
// assumes design, checker and host model are compiled before it
`timescale 1ns/1ps
`include "smi_defs.vh"
module smi_event_aggregator_tb;
  reg i_clock = 1'b0;
  reg i_rstn = 1'b0;
  reg [9:0] adr = 10'h000;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdat = 32'h00000000;
  reg [3:0] be = 4'hF;
  reg [7:0] s1 = 8'h00;
  reg [7:0] s2 = 8'h00;
  reg ir_a = 1'b0;
  reg ir_b = 1'b0;
  reg ir_sel = 1'b0;
  reg [31:0] seen;
  wire [31:0] rdat;
  wire wait_w, grp_n, ser, irq;
  wire [7:0] entries;
  integer err_count = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer k;
  smi_event_aggregator i_smi_event_aggregator (.i_clock(i_clock),
    .i_rstn(i_rstn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wait_w),
    .i_parallel_req(s1[1]), .i_uart_b_req(s1[2]), .i_uart_a_req(s1[3]),
    .i_floppy_req(s1[4]), .i_watchdog_req(s1[7]), .i_mouse_req(s2[0]),
    .i_keyboard_req(s2[1]), .i_kbc_port_line(s2[4]),
    .i_ir_rx_primary(ir_a), .i_ir_rx_alternate(ir_b),
    .i_ir_rx_select(ir_sel), .o_group_sysmgmt_irq_n(grp_n),
    .o_serial_irq_smi_req(ser), .o_irq(irq));
  smi_host_model i_smi_host_model (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_group_n(grp_n), .o_entries(entries));
  always #10 i_clock = ~i_clock;
  // a hung handshake ends here instead of spinning forever
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count = err_count + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge i_clock);
  endtask
  // one access: held until waitrequest is sampled low
  task bus(input w, input [7:0] idx, input [31:0] d);
    begin
      adr <= {idx, 2'b00};
      wdat <= d;
      rd <= !w;
      wr <= w;
      @(posedge i_clock);
      while (wait_w !== 1'b0) @(posedge i_clock);
      seen = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge i_clock);
    end
  endtask
  task chk_reg(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chk_pin(input got, input exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask
  task rd_chk(input [7:0] idx, input [31:0] exp);
    begin
      bus(1'b0, idx, 32'h0);
      chk_reg(seen, exp);
    end
  endtask
  task t_reset;
    begin
      for (k = `IDX_ENABLE_1; k <= `IDX_EVENT_MASK; k = k + 1)
        rd_chk(k, 32'h0);
      rd_chk(8'hC0, 32'h0);
      chk_pin(grp_n, 1'b1);
      $display("test reset done");
    end
  endtask
  task t_group1;
    begin
      bus(1'b1, `IDX_ENABLE_1, 32'hFF);
      rd_chk(`IDX_ENABLE_1, 32'h9E);
      for (k = 0; k < 8; k = k + 1) if (`MASK_GROUP_1 & (8'h01 << k)) begin
        s1 <= 8'h01 << k;
        tick(3);
        chk_pin(grp_n, 1'b0);
        rd_chk(`IDX_STATUS_1, 32'h1 << k);
        bus(1'b1, `IDX_ENABLE_1, `MASK_GROUP_1 & ~(8'h01 << k));
        tick(2);
        chk_pin(grp_n, 1'b1);
        s1 <= 8'h00;
        tick(3);
        bus(1'b1, `IDX_ENABLE_1, 32'h9E);
        chk_pin(grp_n, 1'b1);
      end
      chk_reg(entries, 32'h5);
      s1 <= 8'h80;
      tick(3);
      bus(1'b1, `IDX_STATUS_1, 32'h0);
      rd_chk(`IDX_STATUS_1, 32'h80);
      rd_chk(`IDX_STATUS_1, 32'h80);
      s1 <= 8'h00;
      tick(3);
      rd_chk(`IDX_STATUS_1, 32'h0);
      $display("test group1 done");
    end
  endtask
  task t_group2;
    begin
      bus(1'b1, `IDX_ENABLE_2, 32'hFF);
      rd_chk(`IDX_ENABLE_2, 32'h57);
      for (k = 0; k < 8; k = k + 1) if (8'h13 & (8'h01 << k)) begin
        s2 <= 8'h01 << k;
        tick(3);
        chk_pin(grp_n, 1'b0);
        chk_pin(ser, 1'b1);
        rd_chk(`IDX_STATUS_2, 32'h1 << k);
        s2 <= 8'h00;
        tick(3);
        chk_pin(grp_n, 1'b1);
        rd_chk(`IDX_STATUS_2, 32'h0);
      end
      bus(1'b1, `IDX_ENABLE_2, 32'h17);
      s2 <= 8'h01;
      tick(3);
      chk_pin(ser, 1'b0);
      be <= 4'hE;
      bus(1'b1, `IDX_ENABLE_2, 32'h16);
      be <= 4'hF;
      rd_chk(`IDX_ENABLE_2, 32'h17);
      bus(1'b1, `IDX_ENABLE_2, 32'h16);
      tick(2);
      chk_pin(grp_n, 1'b1);
      s2 <= 8'h00;
      $display("test group2 done");
    end
  endtask
  task t_infra;
    begin
      bus(1'b1, `IDX_ENABLE_2, 32'h04);
      ir_a <= 1'b1;
      tick(5);
      chk_pin(grp_n, 1'b0);
      rd_chk(`IDX_STATUS_2, 32'h4);
      rd_chk(`IDX_STATUS_2, 32'h0);
      tick(2);
      chk_pin(grp_n, 1'b1);
      ir_sel <= 1'b1;
      tick(5);
      bus(1'b0, `IDX_STATUS_2, 32'h0);
      ir_b <= 1'b1;
      tick(5);
      rd_chk(`IDX_STATUS_2, 32'h4);
      ir_a <= 1'b0;
      tick(5);
      rd_chk(`IDX_STATUS_2, 32'h0);
      ir_b <= 1'b0;
      tick(5);
      rd_chk(`IDX_STATUS_2, 32'h4);
      $display("test infrared done");
    end
  endtask
  task t_event;
    begin
      bus(1'b1, `IDX_EVENT, 32'hFFFF);
      bus(1'b1, `IDX_EVENT_MASK, 32'hFFFF);
      s1 <= 8'h02;
      tick(4);
      rd_chk(`IDX_EVENT, 32'h2);
      chk_pin(irq, 1'b1);
      bus(1'b1, `IDX_EVENT_MASK, 32'h0);
      tick(2);
      chk_pin(irq, 1'b0);
      bus(1'b1, `IDX_EVENT, 32'h2);
      rd_chk(`IDX_EVENT, 32'h0);
      bus(1'b1, `IDX_EVENT_MASK, 32'hFFFF);
      tick(2);
      chk_pin(irq, 1'b0);
      s1 <= 8'h00;
      $display("test event done");
    end
  endtask
  initial begin
    tick(10);
    i_rstn <= 1'b1;
    tick(1);
    t_reset;
    t_group1;
    t_group2;
    t_infra;
    t_event;
    report_and_stop;
  end
endmodule
